// >>> src/lpmc_pkg.sv
// Purpose: Shared constants and types for the low-power mode controller
// Assumes: 32-bit AHB-Lite register bus, 20 MHz hclk
// Notes:   Register offsets are byte addresses
package lpmc_pkg;

  // Power modes, Gray coded along run-wait-stop paths
  typedef enum logic [2:0] {
    LPMC_RUN    = 3'h0,
    LPMC_WAIT   = 3'h1,
    LPMC_LSTOP  = 3'h3,
    LPMC_DSTOP  = 3'h2,
    LPMC_LOW_POWER_RUN  = 3'h6,
    LPMC_LOW_POWER_WAIT = 3'h7
  } lpmc_mode_t;

  // Register byte offsets
  localparam logic [7:0] LPMC_OFS_CTRL  = 8'h00;
  localparam logic [7:0] LPMC_OFS_CLKG  = 8'h04;
  localparam logic [7:0] LPMC_OFS_GATE1 = 8'h08;
  localparam logic [7:0] LPMC_OFS_GATE2 = 8'h0c;
  localparam logic [7:0] LPMC_OFS_STAT  = 8'h10;
  localparam logic [7:0] LPMC_OFS_CMD   = 8'h14;

  // Control register fields
  localparam int LPMC_CTRL_LPR   = 0;
  localparam int LPMC_CTRL_LOW_POWER_WAKEUP_SELECT = 1;
  localparam int LPMC_CTRL_LOW_VOLTAGE_DETECT_ENABLE  = 2;
  localparam int LPMC_CTRL_LOW_VOLTAGE_STOP_ENABLE = 3;
  localparam int LPMC_CTRL_DSTOP = 4;
  localparam int LPMC_CTRL_W     = 5;

  // Clock generator fields
  localparam int LPMC_CLKG_IRCLK = 0;
  localparam int LPMC_CLKG_IRST  = 1;
  localparam int LPMC_CLKG_ERCLK = 2;
  localparam int LPMC_CLKG_ERST  = 3;
  localparam int LPMC_CLKG_W     = 4;

  // Command register fields (write-one pulses)
  localparam int LPMC_CMD_WAIT = 0;
  localparam int LPMC_CMD_STOP = 1;

  // Status fields
  localparam int LPMC_STAT_MODE = 0;
  localparam int LPMC_STAT_LOW_POWER_RUN_STATUS = 3;

  localparam int LPMC_GATE_W = 8;

  // Reset values: all peripheral clocks enabled
  localparam logic [LPMC_GATE_W-1:0] LPMC_GATE_RST = 8'hff;
  localparam logic [LPMC_CTRL_W-1:0] LPMC_CTRL_RST = 5'h00;
  localparam logic [LPMC_CLKG_W-1:0] LPMC_CLKG_RST = 4'h0;

  localparam logic [1:0] LPMC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] LPMC_HSIZE_WORD    = 3'h2;

endpackage : lpmc_pkg

// >>> src/lpmc_if.sv
// Purpose: Control bits passed from the register file to the mode sequencer
// Assumes: Same clock for both ends
// Notes:   Command strobes are one-cycle pulses
interface lpmc_if;
  logic                               low_power_run_select;
  logic                               low_power_wakeup_select;
  logic                               low_voltage_detect_enable;
  logic                               low_voltage_stop_enable;
  logic                               dstop_sel;
  logic                               wait_cmd;
  logic                               stop_cmd;
  logic                               lpr_clear;
  lpmc_pkg::lpmc_mode_t               mode;
  logic                               low_power_run_status;

  modport regs (output low_power_run_select, low_power_wakeup_select, low_voltage_detect_enable, low_voltage_stop_enable, dstop_sel, wait_cmd, stop_cmd,
                input lpr_clear, mode, low_power_run_status);
  modport seq  (input low_power_run_select, low_power_wakeup_select, low_voltage_detect_enable, low_voltage_stop_enable, dstop_sel, wait_cmd, stop_cmd,
                output lpr_clear, mode, low_power_run_status);
endinterface : lpmc_if

// >>> src/lpmc_seq.sv
// Purpose: Power mode sequencer
// Assumes: Wake inputs already synchronised
// Notes:   Holds the current mode and low-power run status
module lpmc_seq (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Control
  lpmc_if.seq       ctl,
  input  wire logic dbg_en,
  input  wire logic irq_wake,
  input  wire logic pin_wake,
  output logic      por_req
);

  typedef struct packed {
    lpmc_pkg::lpmc_mode_t mode;
    logic                 low_power_run_status;
    logic                 por;
  } lpmc_seq_t;

  lpmc_seq_t st_r;
  lpmc_seq_t st_nxt;
  logic      lp_block;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.por = 1'b0;
    lp_block   = dbg_en | (ctl.low_voltage_detect_enable & ctl.low_voltage_stop_enable);
    ctl.lpr_clear = 1'b0;
    case (st_r.mode)
      lpmc_pkg::LPMC_RUN: begin
        if (ctl.low_power_run_select && !lp_block) begin
          st_nxt.mode = lpmc_pkg::LPMC_LOW_POWER_RUN;
          st_nxt.low_power_run_status = 1'b1;
        end else if (ctl.wait_cmd) begin
          st_nxt.mode = lpmc_pkg::LPMC_WAIT;
        end else if (ctl.stop_cmd) begin
          if (ctl.dstop_sel && !lp_block) begin
            st_nxt.mode = lpmc_pkg::LPMC_DSTOP;
          end else begin
            st_nxt.mode = lpmc_pkg::LPMC_LSTOP;
          end
        end
      end
      lpmc_pkg::LPMC_WAIT: begin
        if (irq_wake) begin
          st_nxt.mode = lpmc_pkg::LPMC_RUN;
        end
      end
      lpmc_pkg::LPMC_LOW_POWER_RUN: begin
        if (!ctl.low_power_run_select || lp_block) begin
          st_nxt.mode = lpmc_pkg::LPMC_RUN;
          st_nxt.low_power_run_status = 1'b0;
        end else if (ctl.wait_cmd) begin
          st_nxt.mode = lpmc_pkg::LPMC_LOW_POWER_WAIT;
        end else if (ctl.stop_cmd) begin
          st_nxt.mode = lpmc_pkg::LPMC_LSTOP;
        end
      end
      lpmc_pkg::LPMC_LOW_POWER_WAIT: begin
        if (irq_wake) begin
          if (ctl.low_power_wakeup_select) begin
            st_nxt.mode   = lpmc_pkg::LPMC_RUN;
            st_nxt.low_power_run_status   = 1'b0;
            ctl.lpr_clear = 1'b1;
          end else begin
            st_nxt.mode = lpmc_pkg::LPMC_LOW_POWER_RUN;
          end
        end
      end
      lpmc_pkg::LPMC_LSTOP: begin
        if (irq_wake) begin
          if (!st_r.low_power_run_status) begin
            st_nxt.mode = lpmc_pkg::LPMC_RUN;
          end else if (ctl.low_power_wakeup_select) begin
            st_nxt.mode   = lpmc_pkg::LPMC_RUN;
            st_nxt.low_power_run_status   = 1'b0;
            ctl.lpr_clear = 1'b1;
          end else begin
            st_nxt.mode = lpmc_pkg::LPMC_LOW_POWER_RUN;
          end
        end
      end
      lpmc_pkg::LPMC_DSTOP: begin
        if (pin_wake) begin
          st_nxt.por = 1'b1;
        end
      end
      default: begin
        st_nxt.mode = lpmc_pkg::LPMC_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '{mode: lpmc_pkg::LPMC_RUN, low_power_run_status: 1'b0, por: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctl.mode = st_r.mode;
  assign ctl.low_power_run_status = st_r.low_power_run_status;
  assign por_req  = st_r.por;

endmodule : lpmc_seq

// >>> src/lpmc_top.sv
// Purpose: Low-power mode controller with AHB-Lite register access
// Assumes: 20 MHz hclk, reset ends any stop mode
// Notes:   Wake and debug inputs are synchronised here
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.

// How it works
// - Any stop halts all peripheral clocks
// - Debug clock survives light stop when enabled, off in deep stop
// - Low-power modes gate clocks per register bits
// - Debug enabled turns deep stop into light
// - Debug enabled keeps normal run or wait
// - Low-voltage stop turns deep into light
// - Low-voltage stop keeps normal run or wait
// - Light stop exits to run on reset/interrupt, or to low-power run if entered from it without wakeup select
// - Clock generator on in light stop only if both set, off in deep stop
// - Oscillator on in light stop only if both set, always on in deep stop
// - Regulator full on in run or wait, in light stop only with detection
// - Wake pin in deep stop triggers power-on
// - Wakeup select clears low-power run bits
module lpmc_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Asynchronous inputs
  input  wire logic        debug_keep_alive_enable,
  input  wire logic        irq_in,
  input  wire logic        wake_pin,
  // Power control outputs
  output logic      [7:0]  periph_clk_en_one,
  output logic      [7:0]  periph_clk_en_two,
  output logic             cpu_clk_en,
  output logic             debug_clk_en,
  output logic             clock_gen_on,
  output logic             ext_osc_on,
  output logic             regulator_full_on,
  output logic             regulator_partial_off,
  output logic             por_request
);

  typedef struct packed {
    logic [lpmc_pkg::LPMC_CTRL_W-1:0]  ctrl;
    logic [lpmc_pkg::LPMC_CLKG_W-1:0]  clkg;
    logic [lpmc_pkg::LPMC_GATE_W-1:0]  gate1;
    logic [lpmc_pkg::LPMC_GATE_W-1:0]  gate2;
    logic                              wr_pend;
    logic [7:0]                        wr_addr;
    logic                              wcmd;
    logic                              scmd;
    logic [31:0]                       rdata;
    logic [2:0]                        sync_a;
    logic [2:0]                        sync_b;
    logic [7:0]                        pen1;
    logic [7:0]                        pen2;
    logic [5:0]                        outs;
  } lpmc_top_t;

  lpmc_top_t st_r;
  lpmc_top_t st_nxt;
  lpmc_if    ctl ();
  logic      acc;
  logic      dbg_s;
  logic      irq_s;
  logic      wake_s;
  logic      stop_m;
  logic      low_m;
  logic      por_int;

  lpmc_seq u_seq (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ctl      (ctl.seq),
    .dbg_en   (dbg_s),
    .irq_wake (irq_s),
    .pin_wake (wake_s),
    .por_req  (por_int)
  );

  assign dbg_s  = st_r.sync_b[0];
  assign irq_s  = st_r.sync_b[1];
  assign wake_s = st_r.sync_b[2];
  assign acc    = hsel & hready & (htrans == lpmc_pkg::LPMC_HTRANS_NONSEQ);

  assign ctl.low_power_run_select       = st_r.ctrl[lpmc_pkg::LPMC_CTRL_LPR];
  assign ctl.low_power_wakeup_select     = st_r.ctrl[lpmc_pkg::LPMC_CTRL_LOW_POWER_WAKEUP_SELECT];
  assign ctl.low_voltage_detect_enable      = st_r.ctrl[lpmc_pkg::LPMC_CTRL_LOW_VOLTAGE_DETECT_ENABLE];
  assign ctl.low_voltage_stop_enable     = st_r.ctrl[lpmc_pkg::LPMC_CTRL_LOW_VOLTAGE_STOP_ENABLE];
  assign ctl.dstop_sel = st_r.ctrl[lpmc_pkg::LPMC_CTRL_DSTOP];
  assign ctl.wait_cmd  = st_r.wcmd;
  assign ctl.stop_cmd  = st_r.scmd;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.sync_a = {wake_pin, irq_in, debug_keep_alive_enable};
    st_nxt.sync_b = st_r.sync_a;
    st_nxt.wcmd   = 1'b0;
    st_nxt.scmd   = 1'b0;
    stop_m = (ctl.mode == lpmc_pkg::LPMC_LSTOP) || (ctl.mode == lpmc_pkg::LPMC_DSTOP);
    low_m  = (ctl.mode == lpmc_pkg::LPMC_LOW_POWER_RUN) || (ctl.mode == lpmc_pkg::LPMC_LOW_POWER_WAIT);
    // Write data phase
    st_nxt.wr_pend = acc & hwrite;
    st_nxt.wr_addr = haddr;
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        lpmc_pkg::LPMC_OFS_CTRL:  st_nxt.ctrl  = hwdata[lpmc_pkg::LPMC_CTRL_W-1:0];
        lpmc_pkg::LPMC_OFS_CLKG:  st_nxt.clkg  = hwdata[lpmc_pkg::LPMC_CLKG_W-1:0];
        lpmc_pkg::LPMC_OFS_GATE1: st_nxt.gate1 = hwdata[lpmc_pkg::LPMC_GATE_W-1:0];
        lpmc_pkg::LPMC_OFS_GATE2: st_nxt.gate2 = hwdata[lpmc_pkg::LPMC_GATE_W-1:0];
        lpmc_pkg::LPMC_OFS_CMD: begin
          st_nxt.wcmd = hwdata[lpmc_pkg::LPMC_CMD_WAIT];
          st_nxt.scmd = hwdata[lpmc_pkg::LPMC_CMD_STOP];
        end
        default: begin
        end
      endcase
    end
    if (ctl.lpr_clear) begin
      st_nxt.ctrl[lpmc_pkg::LPMC_CTRL_LPR] = 1'b0;
    end
    // Read data captured in address phase
    st_nxt.rdata = 32'h0;
    if (acc && !hwrite) begin
      case (haddr)
        lpmc_pkg::LPMC_OFS_CTRL:  st_nxt.rdata[lpmc_pkg::LPMC_CTRL_W-1:0] = st_r.ctrl;
        lpmc_pkg::LPMC_OFS_CLKG:  st_nxt.rdata[lpmc_pkg::LPMC_CLKG_W-1:0] = st_r.clkg;
        lpmc_pkg::LPMC_OFS_GATE1: st_nxt.rdata[lpmc_pkg::LPMC_GATE_W-1:0] = st_r.gate1;
        lpmc_pkg::LPMC_OFS_GATE2: st_nxt.rdata[lpmc_pkg::LPMC_GATE_W-1:0] = st_r.gate2;
        lpmc_pkg::LPMC_OFS_STAT: begin
          st_nxt.rdata[lpmc_pkg::LPMC_STAT_MODE +: 3] = ctl.mode;
          st_nxt.rdata[lpmc_pkg::LPMC_STAT_LOW_POWER_RUN_STATUS]      = ctl.low_power_run_status;
        end
        default: begin
        end
      endcase
    end
    if (stop_m) begin
      st_nxt.pen1 = 8'h00;
      st_nxt.pen2 = 8'h00;
    end else if (low_m) begin
      st_nxt.pen1 = st_r.gate1;
      st_nxt.pen2 = st_r.gate2;
    end else begin
      st_nxt.pen1 = 8'hff;
      st_nxt.pen2 = 8'hff;
    end
    // Output bits: cpu, debug, clkgen, osc, reg full, reg partial
    st_nxt.outs[0] = (ctl.mode == lpmc_pkg::LPMC_RUN) || (ctl.mode == lpmc_pkg::LPMC_LOW_POWER_RUN);
    st_nxt.outs[1] = dbg_s && (ctl.mode != lpmc_pkg::LPMC_DSTOP);
    st_nxt.outs[2] = (ctl.mode == lpmc_pkg::LPMC_LSTOP)
                     ? (st_r.clkg[lpmc_pkg::LPMC_CLKG_IRCLK] && st_r.clkg[lpmc_pkg::LPMC_CLKG_IRST])
                     : (ctl.mode != lpmc_pkg::LPMC_DSTOP);
    st_nxt.outs[3] = (ctl.mode == lpmc_pkg::LPMC_LSTOP)
                     ? (st_r.clkg[lpmc_pkg::LPMC_CLKG_ERCLK] && st_r.clkg[lpmc_pkg::LPMC_CLKG_ERST])
                     : 1'b1;
    st_nxt.outs[4] = (ctl.mode == lpmc_pkg::LPMC_LSTOP) ? (ctl.low_voltage_detect_enable && ctl.low_voltage_stop_enable)
                     : (ctl.mode == lpmc_pkg::LPMC_RUN) || (ctl.mode == lpmc_pkg::LPMC_WAIT);
    st_nxt.outs[5] = (ctl.mode == lpmc_pkg::LPMC_DSTOP);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r       <= '0;
      st_r.ctrl  <= lpmc_pkg::LPMC_CTRL_RST;
      st_r.clkg  <= lpmc_pkg::LPMC_CLKG_RST;
      st_r.gate1 <= lpmc_pkg::LPMC_GATE_RST;
      st_r.gate2 <= lpmc_pkg::LPMC_GATE_RST;
      st_r.pen1  <= 8'hff;
      st_r.pen2  <= 8'hff;
      st_r.outs  <= 6'h1d;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata                = st_r.rdata;
  assign hreadyout             = 1'b1;
  assign hresp                 = 1'b0;
  assign periph_clk_en_one     = st_r.pen1;
  assign periph_clk_en_two     = st_r.pen2;
  assign cpu_clk_en            = st_r.outs[0];
  assign debug_clk_en          = st_r.outs[1];
  assign clock_gen_on          = st_r.outs[2];
  assign ext_osc_on            = st_r.outs[3];
  assign regulator_full_on     = st_r.outs[4];
  assign regulator_partial_off = st_r.outs[5];
  assign por_request           = por_int;

  // Assertions
  a_stop_gates: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.mode == lpmc_pkg::LPMC_LSTOP) |=> (periph_clk_en_one == 8'h00))
    else $error("peripheral clocks not halted in stop");
  a_debug_clock: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.mode == lpmc_pkg::LPMC_LSTOP && dbg_s) |=> debug_clk_en)
    else $error("debug clock lost in stop");
  a_lp_gating: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.mode == lpmc_pkg::LPMC_LOW_POWER_RUN) |=> (periph_clk_en_two == $past(st_r.gate2)))
    else $error("low-power gating mismatch");
  a_dbg_no_deep: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.mode == lpmc_pkg::LPMC_RUN && ctl.stop_cmd && dbg_s)
    |=> (ctl.mode == lpmc_pkg::LPMC_LSTOP))
    else $error("deep stop entered with debug on");
  a_dbg_no_low_power_run: assert property (@(posedge hclk) disable iff (!hresetn)
    dbg_s |=> (ctl.mode != lpmc_pkg::LPMC_LOW_POWER_RUN) || !$past(ctl.mode == lpmc_pkg::LPMC_RUN))
    else $error("low-power run entered with debug on");
  a_lvd_no_deep: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.mode == lpmc_pkg::LPMC_RUN && ctl.stop_cmd && ctl.low_voltage_detect_enable && ctl.low_voltage_stop_enable)
    |=> (ctl.mode == lpmc_pkg::LPMC_LSTOP))
    else $error("deep stop entered with detection on");
  a_lstop_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.mode == lpmc_pkg::LPMC_LSTOP && irq_s && !ctl.low_power_run_status)
    |=> (ctl.mode == lpmc_pkg::LPMC_RUN))
    else $error("light stop did not wake to run");
  a_reg_standby: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.mode == lpmc_pkg::LPMC_LSTOP && !ctl.low_voltage_detect_enable) |=> !regulator_full_on)
    else $error("regulator full on without detection");
  a_pin_por: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.mode == lpmc_pkg::LPMC_DSTOP && wake_s) |=> por_request)
    else $error("wake pin did not request power-on");
  a_low_power_wait_run: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.mode == lpmc_pkg::LPMC_LOW_POWER_WAIT && irq_s && ctl.low_power_wakeup_select)
    |=> (ctl.mode == lpmc_pkg::LPMC_RUN) ##1 !ctl.low_power_run_select)
    else $error("low-power wait wake wrong");

  c_wait: cover property (@(posedge hclk) disable iff (!hresetn)
    ctl.mode == lpmc_pkg::LPMC_WAIT ##1 ctl.mode == lpmc_pkg::LPMC_RUN);
  c_lstop: cover property (@(posedge hclk) disable iff (!hresetn)
    ctl.mode == lpmc_pkg::LPMC_LSTOP);
  c_dstop: cover property (@(posedge hclk) disable iff (!hresetn)
    ctl.mode == lpmc_pkg::LPMC_DSTOP);
  c_low_power_wait: cover property (@(posedge hclk) disable iff (!hresetn)
    ctl.mode == lpmc_pkg::LPMC_LOW_POWER_WAIT);

endmodule : lpmc_top

// >>> testbench/lpmc_cpu.sv
// Purpose: CPU core model, the AHB-Lite master of the controller
// Assumes: One slave, single word transfers
// Notes:   A phase longer than 50 cycles raises bus_tmo
module lpmc_cpu (
  // Clock and answer
  input  logic        hclk,
  input  logic        hreadyout,
  input  logic [31:0] hrdata,
  // Requests
  output logic        hsel,
  output logic [7:0]  haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [31:0] hwdata,
  // Hang flag
  output logic        bus_tmo
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    bus_tmo = 1'b0;
  end

  // Hold until hready seen high
  task automatic phase;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      bus_tmo <= 1'b1;
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= lpmc_pkg::LPMC_HTRANS_NONSEQ;
    phase();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    phase();
    r = hrdata;
  endtask
endmodule // lpmc_cpu

// >>> testbench/lpmc_bench.sv
// Purpose: Self-checking bench of the mode controller
// Assumes: Zero-wait slave, 50 ns clock
// Notes:   Status read gives low_power_run_status and mode
module lpmc_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, bus_tmo;
  logic        debug_keep_alive_enable, irq_in, wake_pin;
  logic [7:0]  haddr, periph_clk_en_one, periph_clk_en_two;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rdv;
  logic        cpu_clk_en, debug_clk_en, clock_gen_on, ext_osc_on;
  logic        regulator_full_on, regulator_partial_off, por_request;
  int          err_count;
  int          n_compared;

  lpmc_cpu lpmc_cpu_inst (.hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite,
                          .hwdata, .bus_tmo);

  lpmc_top lpmc_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(lpmc_pkg::LPMC_HSIZE_WORD), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .debug_keep_alive_enable, .irq_in, .wake_pin, .periph_clk_en_one,
    .periph_clk_en_two, .cpu_clk_en, .debug_clk_en, .clock_gen_on, .ext_osc_on,
    .regulator_full_on, .regulator_partial_off, .por_request);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    lpmc_cpu_inst.xfer(1'b1, a, d, rdv);
  endtask

  task automatic rd(input logic [7:0] a);
    lpmc_cpu_inst.xfer(1'b0, a, 32'h0, rdv);
  endtask

  task automatic settle;
    repeat (6) @(posedge hclk);
  endtask

  task automatic chk_mode(input lpmc_pkg::lpmc_mode_t m, input logic low_power_run_status, input string msg);
    rd(lpmc_pkg::LPMC_OFS_STAT);
    chk(rdv, {28'h0, low_power_run_status, m}, msg);
  endtask

  task automatic cmd(input logic [31:0] c);
    wr(lpmc_pkg::LPMC_OFS_CMD, c);
    settle();
  endtask

  task automatic wake_irq;
    irq_in <= 1'b1;
    settle();
    irq_in <= 1'b0;
    settle();
  endtask

  task automatic s_reset;
    chk({cpu_clk_en, debug_clk_en, regulator_full_on, hresp}, 4'ha, "reset outs");
    rd(lpmc_pkg::LPMC_OFS_GATE2);
    chk(rdv, 32'hff, "gate reset");
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    chk(rdv, 32'h0, "unmapped");
  endtask

  task automatic s_wait;
    cmd(32'h1);
    chk_mode(lpmc_pkg::LPMC_WAIT, 1'b0, "wait");
    chk({cpu_clk_en, periph_clk_en_one}, 9'h0ff, "wait clocks");
    wake_irq();
    chk_mode(lpmc_pkg::LPMC_RUN, 1'b0, "wait exit");
  endtask

  task automatic s_lp;
    wr(lpmc_pkg::LPMC_OFS_GATE1, 32'ha5);
    wr(lpmc_pkg::LPMC_OFS_GATE2, 32'h3c);
    wr(lpmc_pkg::LPMC_OFS_CTRL, 32'h01);
    settle();
    chk_mode(lpmc_pkg::LPMC_LOW_POWER_RUN, 1'b1, "low_power_run");
    chk({periph_clk_en_one, periph_clk_en_two}, 16'ha53c, "low_power_run gates");
    cmd(32'h1);
    chk_mode(lpmc_pkg::LPMC_LOW_POWER_WAIT, 1'b1, "low_power_wait");
    chk({periph_clk_en_one, periph_clk_en_two}, 16'ha53c, "low_power_wait gates");
    wake_irq();
    chk_mode(lpmc_pkg::LPMC_LOW_POWER_RUN, 1'b1, "low_power_wait to low_power_run");
    cmd(32'h2);
    chk_mode(lpmc_pkg::LPMC_LSTOP, 1'b1, "low_power_run stop");
    chk({periph_clk_en_one, periph_clk_en_two}, 16'h0, "stop gates");
    wake_irq();
    chk_mode(lpmc_pkg::LPMC_LOW_POWER_RUN, 1'b1, "stop to low_power_run");
    wr(lpmc_pkg::LPMC_OFS_CTRL, 32'h03);
    cmd(32'h1);
    wake_irq();
    chk_mode(lpmc_pkg::LPMC_RUN, 1'b0, "low_power_wait to run");
    wr(lpmc_pkg::LPMC_OFS_CTRL, 32'h03);
    settle();
    cmd(32'h2);
    wake_irq();
    chk_mode(lpmc_pkg::LPMC_RUN, 1'b0, "stop to run");
    rd(lpmc_pkg::LPMC_OFS_CTRL);
    chk(rdv, 32'h02, "lpr cleared");
  endtask

  task automatic s_block;
    for (int i = 0; i < 2; i++) begin
      debug_keep_alive_enable <= (i == 0);
      settle();
      wr(lpmc_pkg::LPMC_OFS_CTRL, (i == 0) ? 32'h01 : 32'h0d);
      settle();
      chk_mode(lpmc_pkg::LPMC_RUN, 1'b0, "low_power_run refused");
      cmd(32'h1);
      chk_mode(lpmc_pkg::LPMC_WAIT, 1'b0, "normal wait");
      wake_irq();
      wr(lpmc_pkg::LPMC_OFS_CTRL, (i == 0) ? 32'h10 : 32'h1c);
      cmd(32'h2);
      chk_mode(lpmc_pkg::LPMC_LSTOP, 1'b0, "deep refused");
      chk({periph_clk_en_one, periph_clk_en_two}, 16'h0, "stop gates");
      chk(i == 0 ? debug_clk_en : regulator_full_on, 1'b1, "kept alive");
      wake_irq();
      chk_mode(lpmc_pkg::LPMC_RUN, 1'b0, "stop wake");
      wr(lpmc_pkg::LPMC_OFS_CTRL, 32'h0);
      debug_keep_alive_enable <= 1'b0;
    end
  endtask

  task automatic s_osc;
    for (int i = 0; i < 16; i++) begin
      wr(lpmc_pkg::LPMC_OFS_CLKG, 32'(i));
      cmd(32'h2);
      chk({clock_gen_on, ext_osc_on, regulator_full_on}, {i[1] & i[0], i[3] & i[2], 1'b0},
          "stop sources");
      wake_irq();
    end
  endtask

  task automatic s_deep;
    wr(lpmc_pkg::LPMC_OFS_CTRL, 32'h10);
    cmd(32'h2);
    chk_mode(lpmc_pkg::LPMC_DSTOP, 1'b0, "deep");
    chk({periph_clk_en_one, periph_clk_en_two, regulator_partial_off, por_request},
        {16'h0, 2'b10}, "deep outs");
    wake_irq();
    chk_mode(lpmc_pkg::LPMC_DSTOP, 1'b0, "irq ignored");
    wake_pin <= 1'b1;
    settle();
    chk(por_request, 1'b1, "power-on ask");
    hresetn <= 1'b0;
    wake_pin <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_mode(lpmc_pkg::LPMC_RUN, 1'b0, "reset exit");
  endtask

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    err_count = 0;
    n_compared = 0;
    hresetn = 1'b0;
    debug_keep_alive_enable = 1'b0;
    irq_in = 1'b0;
    wake_pin = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_wait();
    s_lp();
    s_block();
    s_osc();
    s_deep();
    end_sim();
  end

  always @(posedge bus_tmo) begin
    err_count++;
    end_sim();
  end
endmodule // lpmc_bench
